// ### rtl/bld_pkg.sv
// shared constants for the backlight dimming control ends
package bld_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  // soft start length in microseconds
  localparam int unsigned SOFT_START_US = 1000;
  localparam int unsigned SOFT_START_CYC = (SOFT_START_US * (CLK_HZ / 1000000));
  // least pwm phase in microseconds
  localparam int unsigned MIN_PHASE_US = 50;
  localparam int unsigned MIN_PHASE_CYC = (MIN_PHASE_US * (CLK_HZ / 1000000));
  // power pwm high count above which soft start is skipped
  localparam logic [2:0] POW_EDGE_LIMIT = 3'h3;
  localparam logic [1:0] DRV_EDGE_LIMIT = 2'h2;
  localparam int unsigned NUM_CH = 6;
  // led current selection codes
  typedef enum logic [1:0] {
    BLD_CUR_OFF = 2'b00,
    BLD_CUR_START = 2'b01,
    BLD_CUR_NORMAL = 2'b10
  } bld_cur_t;
  // host modes
  typedef enum logic [1:0] {
    BLD_MODE_IDLE = 2'b00,
    BLD_MODE_POW = 2'b01,
    BLD_MODE_DRV = 2'b10
  } bld_mode_t;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_DUTY = 8'h04;
  localparam logic [7:0] REG_PERIOD = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [15:0] PERIOD_RST = 16'h2710;
  localparam logic [15:0] DUTY_RST = 16'h1388;
endpackage : bld_pkg

// ### rtl/bld_link_if.sv
// pin level link between the dimming host and the backlight device
`timescale 1ns/100ps
interface bld_link_if;
  logic chip_enable_n;
  logic power_pwm_in;
  logic driver_pwm_in;
  modport host (output chip_enable_n, output power_pwm_in, output driver_pwm_in);
  modport dev (input chip_enable_n, input power_pwm_in, input driver_pwm_in);
endinterface : bld_link_if

// ### rtl/bld_edge_cnt.sv
// saturating rising edge counter cleared while the enable is low
`timescale 1ns/100ps
module bld_edge_cnt #(
  parameter int unsigned W = 3,
  parameter logic [W-1:0] LIMIT = '0
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // control
  input wire logic i_clear,
  input wire logic i_level,
  // result
  output logic o_passed
);
  logic prev_r;
  logic [W-1:0] cnt_r;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || i_clear) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= i_level;
    end
  end

  // saturates so a long pwm run never wraps back into soft start
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || i_clear) begin
      cnt_r <= '0;
    end else if (i_level && !prev_r && (cnt_r != {W{1'b1}})) begin
      cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign o_passed = (cnt_r >= LIMIT);
endmodule : bld_edge_cnt

// ### rtl/bld_dev.sv
// backlight device control logic: power state, soft start and current select
//
// Overview of operation
// - host raises enable and driver pwm before power pwm
// - 1ms soft start, skipped after three power highs
// - soft start skip held until enable goes low
// - host turns lights off via enable low
// - host raises enable and power pwm before driver pwm
// - driver pwm low sinks starting current
// - second driver pwm rise zeroes starting current
// - driver pwm high normal current, low off
// - host driver pwm phases at least 50us
// - host driver pwm 100Hz to 10kHz
// - enable cycle re-arms starting current
// - power pwm high powers on, low powers off
// - host power pwm phases at least 50us
// - host power pwm 100Hz to 1kHz; host does not check period_r, and its reset value gives 2kHz
// - host never pulses enable with power pwm
// - enable and power high select by driver pwm
// - channel use latched until enable low
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/100ps
module bld_dev (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // link from host
  bld_link_if.dev link,
  // channel sense, high when a channel is not grounded
  input wire logic [bld_pkg::NUM_CH-1:0] i_ch_present,
  // current control outputs
  output logic o_powered,
  output logic o_soft_start,
  output logic o_start_cur_en,
  output logic o_skip_soft_start,
  output logic [bld_pkg::NUM_CH-1:0] o_ch_used,
  output bld_pkg::bld_cur_t o_cur_sel
);
  logic en_low;
  logic power_on;
  logic skip_ss;
  logic drv_second;
  logic pow_prev_r;
  logic drv_prev_r;
  logic drv_rise;
  logic [15:0] ss_cnt_r;
  logic ss_active_r;
  logic ch_latched_r;
  logic [bld_pkg::NUM_CH-1:0] ch_used_r;
  bld_pkg::bld_cur_t cur_nxt;
  bld_pkg::bld_cur_t cur_r;

  assign en_low = !link.chip_enable_n;
  assign power_on = link.chip_enable_n && link.power_pwm_in;
  // only driver pin rises seen while powered count, so power pulses with the driver pin held high never
  // clear the starting current
  assign drv_rise = link.driver_pwm_in && !drv_prev_r && power_on;

  // counts power highs; from the fourth high on the power up skips soft start
  bld_edge_cnt #(
    .W(3),
    .LIMIT(bld_pkg::POW_EDGE_LIMIT)
  ) u_pow_cnt (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_clear(en_low),
    .i_level(link.power_pwm_in),
    .o_passed(skip_ss)
  );

  bld_edge_cnt #(
    .W(2),
    .LIMIT(bld_pkg::DRV_EDGE_LIMIT)
  ) u_drv_cnt (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_clear(en_low),
    .i_level(drv_rise),
    .o_passed(drv_second)
  );

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      pow_prev_r <= 1'b0;
    end else begin
      pow_prev_r <= power_on;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      drv_prev_r <= 1'b0;
    end else begin
      drv_prev_r <= link.driver_pwm_in;
    end
  end

  // soft start restarts at each power up unless skipped
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || !power_on) begin
      ss_cnt_r <= 16'h0000;
      ss_active_r <= 1'b0;
    end else if (!pow_prev_r) begin
      ss_cnt_r <= 16'h0000;
      ss_active_r <= !skip_ss;
    end else if (ss_active_r) begin
      if (ss_cnt_r == 16'(bld_pkg::SOFT_START_CYC - 1)) begin
        ss_active_r <= 1'b0;
      end
      ss_cnt_r <= ss_cnt_r + 16'h0001;
    end
  end

  // channel selection is caught at the first power up and kept until enable low
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || en_low) begin
      ch_latched_r <= 1'b0;
      ch_used_r <= '0;
    end else if (power_on && !ch_latched_r) begin
      ch_latched_r <= 1'b1;
      ch_used_r <= i_ch_present;
    end
  end

  always_comb begin
    cur_nxt = bld_pkg::BLD_CUR_OFF;
    if (power_on) begin
      if (link.driver_pwm_in) begin
        cur_nxt = bld_pkg::BLD_CUR_NORMAL;
      end else if (!drv_second) begin
        cur_nxt = bld_pkg::BLD_CUR_START;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      cur_r <= bld_pkg::BLD_CUR_OFF;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  assign o_powered = pow_prev_r;
  assign o_soft_start = ss_active_r;
  assign o_start_cur_en = !drv_second;
  assign o_skip_soft_start = skip_ss;
  assign o_ch_used = ch_used_r;
  assign o_cur_sel = cur_r;
endmodule : bld_dev

// ### rtl/bld_host.sv
// dimming host: register port and enable/pwm pin generation
`timescale 1ns/100ps
module bld_host (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // link to device
  bld_link_if.host link
);
  // ctrl: bit0 enable, bits2:1 mode
  logic en_r;
  bld_pkg::bld_mode_t mode_r;
  logic [15:0] period_r;
  logic [15:0] duty_r;
  logic [15:0] dlo;
  logic [15:0] dhi;
  logic [15:0] cnt_r;
  logic pwm_r;
  logic [31:0] rdata_r;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      en_r <= 1'b0;
      mode_r <= bld_pkg::BLD_MODE_IDLE;
      period_r <= bld_pkg::PERIOD_RST;
      duty_r <= bld_pkg::DUTY_RST;
    end else if (i_wr) begin
      case (i_addr)
        bld_pkg::REG_CTRL: begin
          en_r <= i_wdata[0];
          mode_r <= bld_pkg::bld_mode_t'(i_wdata[2:1]);
        end
        bld_pkg::REG_DUTY: duty_r <= i_wdata[15:0];
        bld_pkg::REG_PERIOD: period_r <= i_wdata[15:0];
        default: ;
      endcase
    end
  end

  // phases clamped to the least width the device can follow
  assign dlo = (duty_r < 16'(bld_pkg::MIN_PHASE_CYC)) ? 16'(bld_pkg::MIN_PHASE_CYC) : duty_r;
  assign dhi = (dlo > period_r - 16'(bld_pkg::MIN_PHASE_CYC)) ?
               (period_r - 16'(bld_pkg::MIN_PHASE_CYC)) : dlo;

  // period register sets the frequency range, software keeps it typical
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || !en_r || mode_r == bld_pkg::BLD_MODE_IDLE) begin
      cnt_r <= 16'h0000;
      pwm_r <= 1'b0;
    end else begin
      cnt_r <= (cnt_r >= period_r - 16'h0001) ? 16'h0000 : cnt_r + 16'h0001;
      pwm_r <= (cnt_r < dhi);
    end
  end

  // enable held steady; pwm goes to one pin only, the other stays high
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      link.chip_enable_n <= 1'b0;
      link.power_pwm_in <= 1'b0;
      link.driver_pwm_in <= 1'b0;
    end else begin
      link.chip_enable_n <= en_r;
      case (mode_r)
        bld_pkg::BLD_MODE_POW: begin
          link.driver_pwm_in <= en_r;
          link.power_pwm_in <= pwm_r && link.driver_pwm_in;
        end
        bld_pkg::BLD_MODE_DRV: begin
          link.power_pwm_in <= en_r;
          link.driver_pwm_in <= pwm_r && link.power_pwm_in;
        end
        default: begin
          link.power_pwm_in <= 1'b0;
          link.driver_pwm_in <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      rdata_r <= 32'h0000_0000;
    end else if (i_rd) begin
      case (i_addr)
        bld_pkg::REG_CTRL: rdata_r <= {29'h0, mode_r, en_r};
        bld_pkg::REG_DUTY: rdata_r <= {16'h0000, duty_r};
        bld_pkg::REG_PERIOD: rdata_r <= {16'h0000, period_r};
        bld_pkg::REG_STATUS: rdata_r <= {29'h0, link.driver_pwm_in, link.power_pwm_in, link.chip_enable_n};
        default: rdata_r <= 32'h0000_0000;
      endcase
    end else begin
      rdata_r <= 32'h0000_0000;
    end
  end

  assign o_rdata = rdata_r;
endmodule : bld_host

// ### dv/bld_link_monitor.sv
// assertions on the pin link and the device outputs
`timescale 1ns/100ps
module bld_link_monitor (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // link pins
  input wire logic chip_enable_n,
  input wire logic power_pwm_in,
  input wire logic driver_pwm_in,
  // device outputs
  input wire logic o_powered,
  input wire logic o_soft_start,
  input wire logic o_start_cur_en,
  input wire logic o_skip_soft_start,
  input wire logic [bld_pkg::NUM_CH-1:0] o_ch_used,
  input wire bld_pkg::bld_cur_t o_cur_sel
);
  logic on;
  logic pow_q;
  logic drv_q;
  logic [2:0] pow_cnt;
  logic [2:0] drv_cnt;
  assign on = chip_enable_n && power_pwm_in;
  always_ff @(posedge i_core_clk) begin
    pow_q <= power_pwm_in;
    drv_q <= driver_pwm_in;
  end
  // own edge counts, so a counter slip in the device shows as a wrong count
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || !chip_enable_n) begin
      pow_cnt <= 3'h0;
      drv_cnt <= 3'h0;
    end else begin
      if (power_pwm_in && !pow_q && pow_cnt != 3'h7) pow_cnt <= pow_cnt + 3'h1;
      if (on && driver_pwm_in && !drv_q && drv_cnt != 3'h7) drv_cnt <= drv_cnt + 3'h1;
    end
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  property p_norm; on && driver_pwm_in |=> o_cur_sel == bld_pkg::BLD_CUR_NORMAL; endproperty
  a_norm: assert property (p_norm) else $error("normal current not selected");
  property p_off; !on |=> o_cur_sel == bld_pkg::BLD_CUR_OFF; endproperty
  a_off: assert property (p_off) else $error("current not off");
  property p_start; on && !driver_pwm_in && o_start_cur_en |=> o_cur_sel == bld_pkg::BLD_CUR_START; endproperty
  a_start: assert property (p_start) else $error("starting current missing");
  property p_zero; on && !driver_pwm_in && !o_start_cur_en |=> o_cur_sel == bld_pkg::BLD_CUR_OFF; endproperty
  a_zero: assert property (p_zero) else $error("starting current not zeroed");
  property p_pwr; 1'b1 |=> o_powered == $past(on); endproperty
  a_pwr: assert property (p_pwr) else $error("power state wrong");
  // the skip decision is the one standing when power comes up, not the one after that edge
  property p_soft; $rose(on) |=> o_soft_start != $past(o_skip_soft_start); endproperty
  a_soft: assert property (p_soft) else $error("soft start wrong at power up");
  property p_skip; $rose(o_skip_soft_start) |-> pow_cnt == 3'h3; endproperty
  a_skip: assert property (p_skip) else $error("skip set at wrong count");
  property p_drv2; $fell(o_start_cur_en) |-> drv_cnt == 3'h2; endproperty
  a_drv2: assert property (p_drv2) else $error("start current cleared at wrong edge");
  property p_rearm; !chip_enable_n |=> o_start_cur_en && !o_skip_soft_start; endproperty
  a_rearm: assert property (p_rearm) else $error("enable low did not rearm");
  property p_chan; !chip_enable_n |=> o_ch_used == '0; endproperty
  a_chan: assert property (p_chan) else $error("channel use not cleared");
  c_skip: cover property ($rose(o_skip_soft_start));
  c_zero: cover property ($fell(o_start_cur_en));
  c_soft: cover property (on && o_soft_start);
endmodule : bld_link_monitor

// ### dv/testbench.sv
// self-checking bench joining host and device over the pin link
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [5:0] pres = 6'h2d;
  logic pw;
  logic sf;
  logic se;
  logic sk;
  logic [5:0] used;
  bld_pkg::bld_cur_t cs;
  int error_cnt = 0;
  int cmp_count = 0;
  always #25 clk = ~clk;
  bld_link_if lk ();
  bld_host i_bld_host (.i_core_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .link(lk.host));
  bld_dev i_bld_dev (.i_core_clk(clk), .i_rst_n(rst_n), .link(lk.dev), .i_ch_present(pres), .o_powered(pw),
    .o_soft_start(sf), .o_start_cur_en(se), .o_skip_soft_start(sk), .o_ch_used(used), .o_cur_sel(cs));
  bld_link_monitor i_bld_link_monitor (.i_core_clk(clk), .i_rst_n(rst_n), .chip_enable_n(lk.chip_enable_n),
    .power_pwm_in(lk.power_pwm_in), .driver_pwm_in(lk.driver_pwm_in), .o_powered(pw), .o_soft_start(sf),
    .o_start_cur_en(se), .o_skip_soft_start(sk), .o_ch_used(used), .o_cur_sel(cs));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", e, rdata);
  endtask : rd_chk
  // waits at falling edges for pin s (0 power, 1 driver) to change from another level to lvl
  task automatic wait_edge(input bit s, input logic lvl);
    logic p;
    logic c;
    p = s ? lk.driver_pwm_in : lk.power_pwm_in;
    for (int n = 0; n < 20000; n++) begin
      @(negedge clk);
      c = s ? lk.driver_pwm_in : lk.power_pwm_in;
      if (c === lvl && p !== lvl) break;
      p = c;
    end
  endtask : wait_edge
  task automatic t_regs;
    rd_chk(bld_pkg::REG_CTRL, 32'h0);
    rd_chk(bld_pkg::REG_STATUS, 32'h0);
    rd_chk(bld_pkg::REG_PERIOD, {16'h0, bld_pkg::PERIOD_RST});
    rd_chk(bld_pkg::REG_DUTY, {16'h0, bld_pkg::DUTY_RST});
    wr_reg(bld_pkg::REG_PERIOD, 32'h7d0);
    wr_reg(bld_pkg::REG_DUTY, 32'h3e8);
    rd_chk(bld_pkg::REG_PERIOD, 32'h7d0);
    rd_chk(bld_pkg::REG_DUTY, 32'h3e8);
    rd_chk(8'h10, 32'h0);
  endtask : t_regs
  task automatic t_pow;
    wr_reg(bld_pkg::REG_CTRL, 32'h3);
    for (int i = 1; i <= 4; i++) begin
      wait_edge(1'b0, 1'b1);
      chk("en_drv", 32'h3, {lk.chip_enable_n, lk.driver_pwm_in});
      repeat (2) @(negedge clk);
      chk("skip", i >= 3, sk);
      chk("cur", bld_pkg::BLD_CUR_NORMAL, cs);
      chk("powered", 32'h1, pw);
      chk("used", 32'h2d, used);
      chk("soft", i < 4, sf);
      if (i == 1) begin
        rd_chk(bld_pkg::REG_CTRL, 32'h3);
        rd_chk(bld_pkg::REG_STATUS, 32'h7);
        // channel sense changes while latched; the latched set must not follow it
        @(posedge clk);
        pres <= 6'h3f;
      end
    end
  endtask : t_pow
  task automatic t_off;
    wr_reg(bld_pkg::REG_CTRL, 32'h0);
    repeat (3) @(negedge clk);
    chk("skip", 32'h0, sk);
    chk("start_en", 32'h1, se);
    chk("cur", bld_pkg::BLD_CUR_OFF, cs);
    chk("powered", 32'h0, pw);
    chk("used", 32'h0, used);
  endtask : t_off
  task automatic t_drv;
    wr_reg(bld_pkg::REG_CTRL, 32'h5);
    wait_edge(1'b1, 1'b1);
    chk("en_pow", 32'h3, {lk.chip_enable_n, lk.power_pwm_in});
    chk("soft", 32'h1, sf);
    chk("used", 32'h3f, used);
    wait_edge(1'b1, 1'b0);
    repeat (2) @(negedge clk);
    chk("cur", bld_pkg::BLD_CUR_START, cs);
    wait_edge(1'b1, 1'b1);
    repeat (2) @(negedge clk);
    chk("cur", bld_pkg::BLD_CUR_NORMAL, cs);
    chk("start_en", 32'h0, se);
    wait_edge(1'b1, 1'b0);
    repeat (2) @(negedge clk);
    chk("cur", bld_pkg::BLD_CUR_OFF, cs);
    // power has stood far less than the soft start length here, then well past it
    chk("soft", 32'h1, sf);
    repeat (bld_pkg::SOFT_START_CYC) @(negedge clk);
    chk("soft", 32'h0, sf);
  endtask : t_drv
  task automatic tally_and_finish;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_pow();
    t_off();
    t_drv();
    t_off();
    t_drv();
    tally_and_finish();
  end
endmodule : testbench
